// >>> hdl/share_trim_params.svh
// Constants for the share, trim and power-on configuration bank
`ifndef SHARE_TRIM_PARAMS_SVH
`define SHARE_TRIM_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CURRENT_SHARE_SETTING 8'h2a
`define OFS_TEMPERATURE_GAIN_TRIM 8'h2b
`define OFS_POWER_ON_AND_RAMP_SETTING 8'h2c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CURRENT_SHARE_SETTING 8'h00
`define RST_TEMPERATURE_GAIN_TRIM 8'h00
`define RST_POWER_ON_AND_RAMP_SETTING 8'h00
`define RST_READ_DATA 8'h00
`define READ_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SHARE_DROP_HI 7
`define SHARE_DROP_LO 4
`define SHARE_MATCH_HI 3
`define SHARE_MATCH_LO 0
`define TRIM_POL_BIT 4
`define TRIM_GAIN_HI 3
`define TRIM_GAIN_LO 0
`define PON_SEL_HI 7
`define PON_SEL_LO 6
`define PON_SW_BIT 5
`define PON_DLY_HI 4
`define PON_DLY_LO 3

// ----------------------------------------------------------------
// Temperature trim arithmetic
// ----------------------------------------------------------------
`define TEMP_W 12
`define TEMP_MAX 12'hfff
`define TEMP_ZERO 12'h000
`define TRIM_SHIFT 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 25000000
`define MS_PER_S 1000
`define PON_DLY_HALF_MS 500
`define PON_DLY_ONE_MS 1000
`define PON_DLY_TWO_MS 2000
`define PON_CNT_W 26
`define PON_CNT_ZERO 26'h0000000
`define PON_CNT_ONE 26'h0000001
`define PON_AGE_W 27
`define PON_AGE_ZERO 27'h0000000
`define PON_AGE_ONE 27'h0000001
`define PON_AGE_MAX 27'h7ffffff

`endif

// >>> hdl/share_trim_pkg.sv
// Types for the share, trim and power-on configuration bank
package share_trim_pkg;

  typedef enum logic [1:0] {
    PON_ALWAYS = 2'b00,
    PON_PIN = 2'b01,
    PON_SOFT = 2'b10,
    PON_BOTH = 2'b11
  } pon_mode_e;

  typedef enum logic [1:0] {
    PON_DLY_NONE = 2'b00,
    PON_DLY_HALF = 2'b01,
    PON_DLY_ONE = 2'b10,
    PON_DLY_TWO = 2'b11
  } pon_delay_e;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } pon_state_e;

  typedef struct packed {
    pon_state_e st;
    logic [25:0] cnt;
    logic run;
    logic stop;
    logic [26:0] age;
  } pon_delay_s;

  typedef struct packed {
    logic [7:0] share;
    logic [7:0] trim;
    logic [7:0] pon;
    logic [7:0] rdata;
    logic [11:0] temp;
    logic temp_vld;
    logic ctrl;
  } cfg_bank_s;

endpackage

// >>> hdl/power_on_delay.sv
// Power-on delay sequencer ahead of soft start
`timescale 1ns/1ps
`default_nettype none
`include "share_trim_params.svh"

module power_on_delay #(
  parameter int unsigned DLY_HALF_CYC = `PON_DLY_HALF_MS * (`CLK_HZ / `MS_PER_S),
  parameter int unsigned DLY_ONE_CYC = `PON_DLY_ONE_MS * (`CLK_HZ / `MS_PER_S),
  parameter int unsigned DLY_TWO_CYC = `PON_DLY_TWO_MS * (`CLK_HZ / `MS_PER_S)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_on,
  input wire share_trim_pkg::pon_delay_e dly_sel,
  output logic run,
  output logic stop
);
  import share_trim_pkg::*;

  pon_delay_s s;
  pon_delay_s next_s;
  logic [25:0] target;

  always_comb begin
    case (dly_sel)
      PON_DLY_NONE: target = `PON_CNT_ZERO;
      PON_DLY_HALF: target = 26'(DLY_HALF_CYC);
      PON_DLY_ONE: target = 26'(DLY_ONE_CYC);
      default: target = 26'(DLY_TWO_CYC);
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.stop = 1'b0;
    if (!ctrl_on) begin
      next_s.age = `PON_AGE_ZERO;
    end else if (s.age != `PON_AGE_MAX) begin
      next_s.age = s.age + `PON_AGE_ONE;
    end
    case (s.st)
      ST_OFF: begin
        if (ctrl_on && target == `PON_CNT_ZERO) begin
          next_s.st = ST_RUN;
          next_s.run = 1'b1;
        end else if (ctrl_on) begin
          next_s.st = ST_WAIT;
          next_s.cnt = `PON_CNT_ONE;
        end
      end
      ST_WAIT: begin
        if (!ctrl_on) begin
          next_s.st = ST_OFF;
        end else if (s.cnt >= target) begin
          next_s.st = ST_RUN;
          next_s.run = 1'b1;
        end else begin
          next_s.cnt = s.cnt + `PON_CNT_ONE;
        end
      end
      default: begin
        if (!ctrl_on) begin
          // Shutdown starts at once; the ramp-down shape is the stop logic's job
          next_s.st = ST_OFF;
          next_s.run = 1'b0;
          next_s.stop = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{st: ST_OFF, cnt: `PON_CNT_ZERO, run: 1'b0, stop: 1'b0, age: `PON_AGE_ZERO};
    end else begin
      s <= next_s;
    end
  end

  assign run = s.run;
  assign stop = s.stop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_run_after_delay: assert property (@(posedge clk) disable iff (rst)
    $rose(run) |-> s.age > {1'b0, $past(target)})
    else $error("Run rose before the power-on delay elapsed");
  chk_stop_on_drop: assert property (@(posedge clk) disable iff (rst)
    run && !ctrl_on |=> !run && stop)
    else $error("Run did not end with a stop pulse when control dropped");
  chk_run_no_delay: assert property (@(posedge clk) disable iff (rst)
    !run && ctrl_on && dly_sel == PON_DLY_NONE |=> run)
    else $error("Zero delay setting did not start at once");
  cov_delayed_start: cover property (@(posedge clk) disable iff (rst)
    $rose(run) && dly_sel == PON_DLY_HALF);
  cov_shutdown: cover property (@(posedge clk) disable iff (rst) stop);

endmodule
`default_nettype wire

// >>> hdl/share_trim_power_on_config.sv
// Share, temperature trim and power-on configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "share_trim_params.svh"

module share_trim_power_on_config #(
  parameter int unsigned DLY_HALF_CYC = `PON_DLY_HALF_MS * (`CLK_HZ / `MS_PER_S),
  parameter int unsigned DLY_ONE_CYC = `PON_DLY_ONE_MS * (`CLK_HZ / `MS_PER_S),
  parameter int unsigned DLY_TWO_CYC = `PON_DLY_TWO_MS * (`CLK_HZ / `MS_PER_S)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic power_request_pin,
  input wire logic [11:0] temp_adc_raw,
  input wire logic temp_adc_valid,
  output logic [3:0] share_drop_bits,
  output logic [3:0] share_match_window,
  output logic [11:0] temp_adc_trimmed,
  output logic temp_trimmed_valid,
  output logic supply_enable_control,
  output logic supply_run,
  output logic shutdown_start
);
  import share_trim_pkg::*;

  cfg_bank_s s;
  cfg_bank_s next_s;
  logic [15:0] trim_prod;
  logic [8:0] trim_corr;
  logic [12:0] trim_sum;
  pon_mode_e pon_mode;

  // ----------------------------------------------------------------
  // Temperature gain correction
  // ----------------------------------------------------------------
  // Each trim step is 1/128 of the reading, so code 15 gives about 11.7 %.
  // Shift instead of a divide keeps this a single small multiplier.
  always_comb begin
    trim_prod = temp_adc_raw * s.trim[`TRIM_GAIN_HI:`TRIM_GAIN_LO];
    trim_corr = trim_prod[15:`TRIM_SHIFT];
    if (s.trim[`TRIM_POL_BIT]) begin
      trim_sum = {1'b0, temp_adc_raw} - {4'h0, trim_corr};
    end else begin
      trim_sum = {1'b0, temp_adc_raw} + {4'h0, trim_corr};
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    pon_mode = pon_mode_e'(s.pon[`PON_SEL_HI:`PON_SEL_LO]);
    // Register writes; reserved trim bits are stored as written
    if (reg_wr) begin
      if (reg_addr == `OFS_CURRENT_SHARE_SETTING) begin
        next_s.share = reg_wdata;
      end else if (reg_addr == `OFS_TEMPERATURE_GAIN_TRIM) begin
        next_s.trim = reg_wdata;
      end else if (reg_addr == `OFS_POWER_ON_AND_RAMP_SETTING) begin
        next_s.pon = reg_wdata;
      end
    end
    // Register reads answer one cycle later
    if (reg_rd) begin
      if (reg_addr == `OFS_CURRENT_SHARE_SETTING) begin
        next_s.rdata = s.share;
      end else if (reg_addr == `OFS_TEMPERATURE_GAIN_TRIM) begin
        next_s.rdata = s.trim;
      end else if (reg_addr == `OFS_POWER_ON_AND_RAMP_SETTING) begin
        next_s.rdata = s.pon;
      end else begin
        next_s.rdata = `READ_UNMAPPED;
      end
    end
    // Trimmed reading, saturated at full scale
    next_s.temp_vld = temp_adc_valid;
    if (temp_adc_valid) begin
      if (trim_sum[12]) begin
        next_s.temp = s.trim[`TRIM_POL_BIT] ? `TEMP_ZERO : `TEMP_MAX;
      end else begin
        next_s.temp = trim_sum[11:0];
      end
    end
    // Power-on source selection
    case (pon_mode)
      PON_ALWAYS: next_s.ctrl = 1'b1;
      PON_PIN: next_s.ctrl = power_request_pin;
      PON_SOFT: next_s.ctrl = s.pon[`PON_SW_BIT];
      default: next_s.ctrl = s.pon[`PON_SW_BIT] & power_request_pin;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{share: `RST_CURRENT_SHARE_SETTING, trim: `RST_TEMPERATURE_GAIN_TRIM,
             pon: `RST_POWER_ON_AND_RAMP_SETTING, rdata: `RST_READ_DATA,
             temp: `TEMP_ZERO, temp_vld: 1'b0, ctrl: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign share_drop_bits = s.share[`SHARE_DROP_HI:`SHARE_DROP_LO];
  assign share_match_window = s.share[`SHARE_MATCH_HI:`SHARE_MATCH_LO];
  assign temp_adc_trimmed = s.temp;
  assign temp_trimmed_valid = s.temp_vld;
  assign supply_enable_control = s.ctrl;

  // ----------------------------------------------------------------
  // Delay before soft start
  // ----------------------------------------------------------------
  power_on_delay #(
    .DLY_HALF_CYC(DLY_HALF_CYC),
    .DLY_ONE_CYC(DLY_ONE_CYC),
    .DLY_TWO_CYC(DLY_TWO_CYC)
  ) power_on_delay_i (
    .clk(clk),
    .rst(rst),
    .ctrl_on(s.ctrl),
    .dly_sel(pon_delay_e'(s.pon[`PON_DLY_HI:`PON_DLY_LO])),
    .run(supply_run),
    .stop(shutdown_start)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_drop_write: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `OFS_CURRENT_SHARE_SETTING
      |=> share_drop_bits == $past(reg_wdata[7:4]))
    else $error("Master drop field did not follow write");
  chk_match_write: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `OFS_CURRENT_SHARE_SETTING
      |=> share_match_window == $past(reg_wdata[3:0]))
    else $error("Slave match field did not follow write");
  chk_match_hold: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && reg_addr == `OFS_CURRENT_SHARE_SETTING) |=> $stable(share_match_window))
    else $error("Slave match window changed without a write");
  chk_trim_negative: assert property (@(posedge clk) disable iff (rst)
    temp_adc_valid && s.trim[4] |=> temp_adc_trimmed <= $past(temp_adc_raw))
    else $error("Negative trim raised the reading");
  chk_trim_positive: assert property (@(posedge clk) disable iff (rst)
    temp_adc_valid && !s.trim[4] |=> temp_adc_trimmed >= $past(temp_adc_raw))
    else $error("Positive trim lowered the reading");
  chk_trim_span: assert property (@(posedge clk) disable iff (rst)
    temp_adc_valid && !s.trim[4] && s.trim[3:0] == 4'hf && temp_adc_raw == 12'h800
      |=> temp_adc_trimmed == 12'h8f0)
    else $error("Full positive trim span wrong");
  chk_trim_zero_gain: assert property (@(posedge clk) disable iff (rst)
    temp_adc_valid && s.trim[`TRIM_GAIN_HI:`TRIM_GAIN_LO] == 4'h0
      |=> temp_adc_trimmed == $past(temp_adc_raw))
    else $error("Zero gain trim changed the reading");
  chk_temp_valid_on: assert property (@(posedge clk) disable iff (rst)
    temp_adc_valid |=> temp_trimmed_valid)
    else $error("Trimmed valid missing after a raw reading");
  chk_temp_valid_off: assert property (@(posedge clk) disable iff (rst)
    !temp_adc_valid |=> !temp_trimmed_valid && $stable(temp_adc_trimmed))
    else $error("Trimmed output moved without a raw reading");

  // ----------------------------------------------------------------
  // Register readback and power-on source checks
  // ----------------------------------------------------------------
  // Reserved trim bits are stored, so the whole byte reads back
  chk_read_share: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `OFS_CURRENT_SHARE_SETTING |=> reg_rdata == $past(s.share))
    else $error("Share setting read back wrong");
  chk_read_trim: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `OFS_TEMPERATURE_GAIN_TRIM |=> reg_rdata == $past(s.trim))
    else $error("Gain trim read back wrong");
  chk_read_pon: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == `OFS_POWER_ON_AND_RAMP_SETTING |=> reg_rdata == $past(s.pon))
    else $error("Power-on setting read back wrong");
  chk_always_on: assert property (@(posedge clk) disable iff (rst)
    s.pon[7:6] == 2'b00 |=> supply_enable_control)
    else $error("Always-on mode did not enable");
  chk_pin_only: assert property (@(posedge clk) disable iff (rst)
    s.pon[7:6] == 2'b01 |=> supply_enable_control == $past(power_request_pin))
    else $error("Pin mode did not follow the request pin");
  chk_soft_only: assert property (@(posedge clk) disable iff (rst)
    s.pon[7:6] == 2'b10 |=> supply_enable_control == $past(s.pon[5]))
    else $error("Software mode did not follow bit 5");
  chk_both_sources: assert property (@(posedge clk) disable iff (rst)
    s.pon[7:6] == 2'b11 |=> supply_enable_control == ($past(s.pon[5]) && $past(power_request_pin)))
    else $error("Dual mode did not need pin and bit together");
  chk_run_needs_ctrl: assert property (@(posedge clk) disable iff (rst)
    supply_run && !supply_enable_control |=> !supply_run ##1 !shutdown_start)
    else $error("Run outlived the enable control");
  cov_pin_mode_run: cover property (@(posedge clk) disable iff (rst)
    s.pon[7:6] == 2'b01 && $rose(supply_run));
  cov_both_mode_stop: cover property (@(posedge clk) disable iff (rst)
    s.pon[7:6] == 2'b11 && shutdown_start);
  cov_trim_saturate: cover property (@(posedge clk) disable iff (rst)
    temp_trimmed_valid && temp_adc_trimmed == `TEMP_MAX);

endmodule
`default_nettype wire

// >>> sim/host_model.sv
// Host model issuing register accesses on the strobe port
`timescale 1ns/1ps
`default_nettype none
`include "share_trim_params.svh"
module host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Idle lines flip so a stale value never passes for a request
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = (a == `OFS_TEMPERATURE_GAIN_TRIM) ? (d & 8'h1f) : d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    release_bus();
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    release_bus();
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_share_trim_power_on_config.sv
// Testbench for the share, trim and power-on configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "share_trim_params.svh"
module tb_share_trim_power_on_config;
  import share_trim_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b0;
  logic [11:0] raw = 12'h000;
  logic raw_vld = 1'b0;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic reg_wr, reg_rd, tvld, ctrl, run, stop;
  wire logic [3:0] drop, win;
  wire logic [11:0] tdat;
  int failures = 0;
  int cmp_count = 0;
  int dly[4] = '{0, 5, 10, 20};
  logic [7:0] rd;
  always #20 clk = ~clk;
  host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Small delay counts keep the run short; order of the three is kept
  share_trim_power_on_config #(.DLY_HALF_CYC(5), .DLY_ONE_CYC(10), .DLY_TWO_CYC(20))
  share_trim_power_on_config_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .power_request_pin(pin), .temp_adc_raw(raw), .temp_adc_valid(raw_vld),
    .share_drop_bits(drop), .share_match_window(win), .temp_adc_trimmed(tdat),
    .temp_trimmed_valid(tvld), .supply_enable_control(ctrl), .supply_run(run),
    .shutdown_start(stop));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bounded wait for the enable control to reach a level
  task automatic wait_ctrl(input logic lvl);
    int n;
    n = 0;
    while (ctrl !== lvl && n < 20) begin
      tick();
      n++;
    end
    if (ctrl !== lvl) begin
      failures++;
      $display("ERROR at %0t: enable control stuck", $time);
      end_of_test();
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    check({drop, win, 4'h0}, 12'h000);
    host_model_i.write(`OFS_CURRENT_SHARE_SETTING, 8'h5a);
    check({8'h00, drop}, 12'h005);
    check({8'h00, win}, 12'h00a);
    host_model_i.write(8'h2d, 8'hff);
    host_model_i.read(`OFS_CURRENT_SHARE_SETTING, rd);
    check({4'h0, rd}, 12'h05a);
    host_model_i.read(8'h2d, rd);
    check({4'h0, rd}, 12'h000);
    host_model_i.read(`OFS_POWER_ON_AND_RAMP_SETTING, rd);
    check({4'h0, rd}, 12'h000);
    $display("test regs done");
  endtask
  task automatic t_temp();
    logic [7:0] tr[4] = '{8'h0f, 8'h1f, 8'h0f, 8'h00};
    logic [11:0] rw[4] = '{12'h800, 12'h800, 12'hf80, 12'h123};
    logic [11:0] ex[4] = '{12'h8f0, 12'h710, 12'hfff, 12'h123};
    for (int i = 0; i < 4; i++) begin
      host_model_i.write(`OFS_TEMPERATURE_GAIN_TRIM, tr[i]);
      raw = rw[i];
      raw_vld = 1'b1;
      tick();
      raw_vld = 1'b0;
      raw = ~rw[i];
      check({11'h000, tvld}, 12'h001);
      check(tdat, ex[i]);
      tick();
      check({11'h000, tvld}, 12'h000);
    end
    $display("test temp done");
  endtask
  task automatic t_modes();
    logic [1:0] m;
    logic p, s, e;
    for (int i = 0; i < 16; i++) begin
      m = 2'(i >> 2);
      p = i[1];
      s = i[0];
      e = (m == 2'b00) ? 1'b1 : (m == 2'b01) ? p : (m == 2'b10) ? s : (p & s);
      host_model_i.write(`OFS_POWER_ON_AND_RAMP_SETTING, {m, s, 5'h00});
      pin = p;
      repeat (3) tick();
      check({11'h000, ctrl}, {11'h000, e});
    end
    pin = 1'b0;
    $display("test modes done");
  endtask
  task automatic t_delay(input int c);
    int n;
    host_model_i.write(`OFS_POWER_ON_AND_RAMP_SETTING, {2'b10, 1'b0, 2'(c), 3'h0});
    repeat (3) tick();
    check({11'h000, run}, 12'h000);
    host_model_i.write(`OFS_POWER_ON_AND_RAMP_SETTING, {2'b10, 1'b1, 2'(c), 3'h0});
    wait_ctrl(1'b1);
    n = 0;
    while (run !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    check(12'(n), 12'(dly[c] + 1));
    if (run !== 1'b1) begin
      end_of_test();
    end
    host_model_i.write(`OFS_POWER_ON_AND_RAMP_SETTING, {2'b10, 1'b0, 2'(c), 3'h0});
    wait_ctrl(1'b0);
    tick();
    check({10'h000, run, stop}, 12'h001);
    tick();
    check({11'h000, stop}, 12'h000);
    $display("test delay %0d done", c);
  endtask
  // Control dropped mid-wait: no run and no stop pulse
  task automatic t_abort();
    logic seen;
    seen = 1'b0;
    host_model_i.write(`OFS_POWER_ON_AND_RAMP_SETTING, 8'h38);
    pin = 1'b1;
    host_model_i.write(`OFS_POWER_ON_AND_RAMP_SETTING, 8'hf8);
    wait_ctrl(1'b1);
    repeat (3) tick();
    pin = 1'b0;
    repeat (30) begin
      tick();
      seen = seen | run | stop;
    end
    check({11'h000, seen}, 12'h000);
    $display("test abort done");
  endtask
  initial begin
    repeat (5) tick();
    check({run, ctrl, stop, tvld, 8'h00}, 12'h000);
    repeat (5) tick();
    rst = 1'b0;
    repeat (3) tick();
    check({10'h000, ctrl, run}, 12'h003);
    t_regs();
    t_temp();
    t_modes();
    for (int c = 0; c < 4; c++) begin
      t_delay(c);
    end
    t_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
